// ===== tb/audio_rx_model.sv
// receiving processor model: serial capture and slave clock source
`timescale 1ns/1ps
module audio_rx_model (
  input  wire logic       i_gen,
  input  wire logic       i_rise,
  input  wire logic [1:0] i_skip,
  input  wire logic       i_dsp,
  input  wire logic       i_bit_clk,
  input  wire logic       i_frame_clk,
  input  wire logic       i_sdata,
  output logic            o_ext_bit_clk,
  output logic            o_ext_frame_clk,
  output logic [15:0]     o_first,
  output logic [15:0]     o_second,
  output logic [7:0]      o_byte,
  output logic [7:0]      o_done
);
  logic [31:0] sr;
  logic        last;
  logic        frm;
  logic        prev;
  logic        half;
  int          cnt;
  int          bc;
  wire logic   sclk = i_gen ? o_ext_bit_clk : i_bit_clk;
  wire logic   sfrm = i_gen ? o_ext_frame_clk : i_frame_clk;

  initial begin
    {o_ext_bit_clk, o_ext_frame_clk, last, prev, half} = '0;
    {sr, o_first, o_second, o_byte, o_done} = '0;
    cnt = 99;
    bc = 0;
  end

  // clocks for slave runs: 64 bit clocks per frame, frame moves on a fall
  always begin
    #400;
    if (!i_gen) begin
      o_ext_bit_clk = 1'b0;
      o_ext_frame_clk = 1'b0;
      bc = 0;
    end else begin
      o_ext_bit_clk = ~o_ext_bit_clk;
      if (!o_ext_bit_clk) bc = bc + 1;
      if (!o_ext_bit_clk && bc % 32 == 0) o_ext_frame_clk = ~o_ext_frame_clk;
    end
  end

  task automatic take();
    if (cnt >= i_skip && cnt < i_skip + (i_dsp ? 32 : 16)) begin
      sr = {sr[30:0], i_sdata};
      if (cnt == i_skip + (i_dsp ? 31 : 15)) begin
        if (i_dsp) {o_first, o_second} = sr;
        else if (half) o_first = sr[15:0];
        else o_second = sr[15:0];
        o_byte = 8'((sr[15:0] + 16'h0080) >> 8);
        o_done = o_done + 8'h01;
      end
    end
  endtask

  // slave runs see the frame one sample late, as the port launches late
  always @(sclk) begin
    #1;
    if (sclk === i_rise) begin
      frm = i_gen ? last : sfrm;
      last = sfrm;
      cnt = cnt + 1;
      take();
      if (frm !== prev) begin
        prev = frm;
        if (!i_dsp || frm) begin
          cnt = 0;
          half = frm;
          take();
        end
      end
    end
  end
endmodule : audio_rx_model

// ===== tb/audio_serial_out_test.sv
// self-checking bench for the serial audio output port
`timescale 1ns/1ps
module audio_serial_out_test;
  import audio_out_pkg::*;
  logic                i_clock, i_resetn, i_wr, i_rd, i_sample_valid, clk_en;
  logic                gen_on, rx_rise, rx_dsp, bclk, fclk, sdata, ext_b, ext_f;
  logic [ADDR_W-1:0]   i_addr;
  logic [DATA_W-1:0]   i_wdata, o_rdata;
  logic [SAMPLE_W-1:0] i_sample;
  logic [1:0]          rx_skip;
  logic [15:0]         first_w, second_w;
  logic [7:0]          done_n, byte_w;
  int                  mismatches = 0;
  int                  n_tests = 0;

  always #50 i_clock = ~i_clock;

  audio_serial_out dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sample(i_sample), .i_sample_valid(i_sample_valid),
    .i_ext_bit_clk_in(ext_b), .i_ext_frame_clk_in(ext_f),
    .o_bit_clk_out(bclk), .o_frame_clk_out(fclk), .o_serial_data_out(sdata)
  );

  audio_rx_model rx (
    .i_gen(gen_on), .i_rise(rx_rise), .i_skip(rx_skip), .i_dsp(rx_dsp),
    .i_bit_clk(bclk), .i_frame_clk(fclk), .i_sdata(sdata),
    .o_ext_bit_clk(ext_b), .o_ext_frame_clk(ext_f),
    .o_first(first_w), .o_second(second_w), .o_byte(byte_w), .o_done(done_n)
  );

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic load(input logic [15:0] v);
    @(posedge i_clock);
    i_sample <= v;
    i_sample_valid <= 1'b1;
    @(posedge i_clock);
    i_sample_valid <= 1'b0;
  endtask : load

  task automatic reg_test();
    logic [7:0] d;
    rd(CTRL_ADDR, d);
    check("ctrl reset", 16'(d), 16'(CTRL_RESET));
    wr(CTRL_ADDR, 8'hA5);
    rd(CTRL_ADDR, d);
    check("ctrl rw", 16'(d), 16'h00A5);
    rd(4'hE, d);
    check("unmapped", 16'(d), 16'h0000);
    rd(STATUS_ADDR, d);
    check("idle status", 16'(d), 16'h0000);
    clk_en <= 1'b0;
    wr(CTRL_ADDR, 8'h3C);
    clk_en <= 1'b1;
    rd(CTRL_ADDR, d);
    check("frozen ctrl", 16'(d), 16'h00A5);
  endtask : reg_test

  task automatic wait_lvl(input logic v, inout int n);
    int k;
    for (k = 0; k < 3000 && fclk !== v; k++) begin
      @(posedge i_clock);
      #1 n++;
    end
    if (fclk !== v) begin
      mismatches++;
      conclude();
    end
  endtask : wait_lvl

  task automatic rate_test();
    int n;
    int r;
    for (r = 0; r <= 3; r++) begin
      wr(CTRL_ADDR, {1'b0, 2'(r), 5'h12});
      repeat (3) begin
        n = 0;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
      end
      check("frame period", 16'(n), 16'((r == 2 ? 128 : 64) * BCLK_HALF_CYC));
    end
  endtask : rate_test

  task automatic reserved_test();
    logic seen;
    int k;
    seen = 1'b0;
    wr(CTRL_ADDR, 8'h51);
    load(16'hFFFF);
    repeat (20) @(posedge i_clock);
    for (k = 0; k < 1200; k++) begin
      @(posedge i_clock);
      seen = seen | sdata;
    end
    check("reserved data", 16'(seen), 16'h0000);
  endtask : reserved_test

  task automatic stream_case(input logic [7:0] c, input logic g, input logic ed,
                             input logic [1:0] sk, input logic dsp, input logic [15:0] v);
    logic [7:0] d0;
    int k;
    gen_on <= g;
    rx_rise <= ed;
    rx_skip <= sk;
    rx_dsp <= dsp;
    wr(CTRL_ADDR, c);
    load(v);
    d0 = done_n;
    for (k = 0; k < 4000 && 8'(done_n - d0) < 8'h06; k++) @(posedge i_clock);
    if (8'(done_n - d0) < 8'h06) begin
      mismatches++;
      conclude();
    end
    check("first word", first_w, v);
    check("second word", second_w, v);
    check("rounded byte", 16'(byte_w), 16'(v + 16'h0080) >> 8);
    if (g) check("slave clocks", 16'({bclk, fclk}), 16'h0000);
  endtask : stream_case

  initial begin
    {i_clock, i_resetn, i_wr, i_rd, i_sample_valid, gen_on, rx_dsp} = '0;
    {i_addr, i_wdata, i_sample, rx_skip} = '0;
    {rx_rise, clk_en} = 2'b11;
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    reg_test();
    rate_test();
    reserved_test();
    stream_case(8'h52, 1'b0, 1'b1, 2'h0, 1'b0, 16'h8001);
    stream_case(8'h53, 1'b0, 1'b1, 2'h1, 1'b0, 16'h7FFE);
    stream_case(8'h50, 1'b0, 1'b0, 2'h1, 1'b1, 16'hA5C3);
    stream_case(8'h54, 1'b0, 1'b1, 2'h1, 1'b1, 16'h3C5A);
    stream_case(8'h58, 1'b0, 1'b0, 2'h2, 1'b1, 16'hC001);
    stream_case(8'h5C, 1'b0, 1'b1, 2'h1, 1'b1, 16'h0F0F);
    stream_case(8'h42, 1'b1, 1'b0, 2'h0, 1'b0, 16'hF00D);
    stream_case(8'h43, 1'b1, 1'b0, 2'h1, 1'b0, 16'h1357);
    stream_case(8'h40, 1'b1, 1'b1, 2'h0, 1'b1, 16'hBEEF);
    conclude();
  end
endmodule : audio_serial_out_test

// ===== verilog/audio_out_pkg.sv
// constants shared by the serial audio output port
package audio_out_pkg;

  localparam int          SAMPLE_W      = 16;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;

  // register offsets
  localparam logic [3:0]  CTRL_ADDR     = 4'h0;
  localparam logic [3:0]  STATUS_ADDR   = 4'h1;

  // control field positions
  localparam int          FMT_LSB       = 0;
  localparam int          POL_BIT       = 2;
  localparam int          SHIFT_BIT     = 3;
  localparam int          MASTER_BIT    = 4;
  localparam int          RATE_LSB      = 5;
  localparam logic [7:0]  CTRL_RESET    = 8'h20;

  // status field positions
  localparam int          STAT_BCLK_BIT = 0;
  localparam int          STAT_FRM_BIT  = 1;
  localparam int          STAT_BUSY_BIT = 2;

  // format_select codes
  localparam logic [1:0]  FMT_DSP       = 2'h0;
  localparam logic [1:0]  FMT_RSVD      = 2'h1;
  localparam logic [1:0]  FMT_MSBJ      = 2'h2;
  localparam logic [1:0]  FMT_I2S       = 2'h3;

  // bit_clk_rate_select codes
  localparam logic [1:0]  RATE_32FS     = 2'h1;
  localparam logic [1:0]  RATE_64FS     = 2'h2;
  localparam logic [4:0]  HALF_LAST_32  = 5'h0F;
  localparam logic [4:0]  HALF_LAST_64  = 5'h1F;

  // master bit clock timing
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          BCLK_PERIOD_NS = 800;
  localparam int          BCLK_HALF_CYC  = ((BCLK_PERIOD_NS / 2) / CLK_PERIOD_NS) < 1 ? 1 :
                                           ((BCLK_PERIOD_NS / 2) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    DSP_IDLE,
    DSP_WAIT_R1,
    DSP_WAIT_F1,
    DSP_WAIT_R2,
    DSP_RUN
  } eng_state_t;

endpackage : audio_out_pkg

// ===== verilog/audio_serial_out.sv
// serial audio output port: formats, clocking and register file
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - samples go out MSB first, two's complement
// - format_select picks DSP, reserved, MSB-justified, I2S
// - every format but reserved works as master or slave
// - master drives clocks; slave takes external clocks
// - justified and I2S data change on falling edge
// - same sample sent twice per frame
// - DSP slots 16-31 repeat slots 0-15
// - both frame halves carry the same word
// - DSP launches on rising or falling per polarity
// - shift delays DSP MSB by one bit, pol0 only
// - shift0 pol0: MSB at first rising edge
// - shift0 pol1: MSB at first falling edge
// - shift1 pol0: MSB at second rising edge
// - shift1 pol1: MSB at first falling edge
// - master bit clock is 32fs or 64fs
module audio_serial_out
  import audio_out_pkg::*;
#(
  parameter int HALF_CYC = BCLK_HALF_CYC
) (
  input  wire logic                i_clock,
  input  wire logic                i_resetn,
  input  wire logic                i_clk_en,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [DATA_W-1:0]   i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [DATA_W-1:0]   o_rdata,
  input  wire logic [SAMPLE_W-1:0] i_sample,
  input  wire logic                i_sample_valid,
  input  wire logic                i_ext_bit_clk_in,
  input  wire logic                i_ext_frame_clk_in,
  output logic                     o_bit_clk_out,
  output logic                     o_frame_clk_out,
  output logic                     o_serial_data_out
);

  localparam int HALF_W = $clog2(HALF_CYC + 1);

  generate
    if (HALF_CYC < 1) begin : g_bad_half
      $error("HALF_CYC must be at least one clock cycle");
    end
  endgenerate

  logic [DATA_W-1:0]   ctrl_r;
  logic [DATA_W-1:0]   rdata_r;
  logic [SAMPLE_W-1:0] held_r;
  logic [SAMPLE_W-1:0] word_r;
  logic [1:0]          sync_q;
  logic [HALF_W-1:0]   div_r;
  logic                bclk_gen_r;
  logic                frame_gen_r;
  logic [4:0]          bitcnt_r;
  logic                bclk_q_r;
  logic                frm_q_r;
  logic [31:0]         shift_r;
  logic [5:0]          left_r;
  logic                sdo_r;
  eng_state_t          st_r;

  logic [1:0]          fmt;
  logic                pol;
  logic                shift;
  logic                master;
  logic [1:0]          rate;
  logic [4:0]          half_last;
  logic                bclk_lv;
  logic                frm_lv;
  logic                rise_e;
  logic                fall_e;
  logic                frm_rise;
  logic                frm_fall;
  logic                launch_e;
  logic                dsp_start;
  logic                frame_edge;
  logic                first_emit;
  logic                run_emit;
  logic [SAMPLE_W-1:0] load_word;
  logic [DATA_W-1:0]   status;

  assign fmt    = ctrl_r[FMT_LSB +: 2];
  assign pol    = ctrl_r[POL_BIT];
  assign shift  = ctrl_r[SHIFT_BIT];
  assign master = ctrl_r[MASTER_BIT];
  assign rate   = ctrl_r[RATE_LSB +: 2];

  // register file
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (i_clk_en && i_wr && (i_addr == CTRL_ADDR)) begin
      ctrl_r <= i_wdata;
    end
  end

  always_comb begin
    status                = '0;
    status[STAT_BCLK_BIT] = bclk_q_r;
    status[STAT_FRM_BIT]  = frm_q_r;
    status[STAT_BUSY_BIT] = (st_r != DSP_IDLE);
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      rdata_r <= '0;
    end else if (i_clk_en) begin
      if (i_rd && (i_addr == CTRL_ADDR)) begin
        rdata_r <= ctrl_r;
      end else if (i_rd && (i_addr == STATUS_ADDR)) begin
        rdata_r <= status;
      end else begin
        rdata_r <= '0;
      end
    end
  end

  assign o_rdata = rdata_r;

  // newest converter sample, picked up at each frame start
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      held_r <= '0;
    end else if (i_clk_en && i_sample_valid) begin
      held_r <= i_sample;
    end
  end

  pin_sync #(
    .W (2)
  ) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_clk_en (i_clk_en),
    .i_d      ({i_ext_bit_clk_in, i_ext_frame_clk_in}),
    .o_q      (sync_q)
  );

  // unused rate codes fall back to 32fs
  assign half_last = (rate == RATE_64FS) ? HALF_LAST_64 : HALF_LAST_32;

  // master clock generator; held low in slave mode
  always_ff @(posedge i_clock) begin
    if (!i_resetn || (i_clk_en && !master)) begin
      div_r       <= '0;
      bclk_gen_r  <= 1'b0;
      frame_gen_r <= 1'b0;
      bitcnt_r    <= '0;
    end else if (i_clk_en) begin
      if (div_r == HALF_W'(HALF_CYC - 1)) begin
        div_r      <= '0;
        bclk_gen_r <= ~bclk_gen_r;
        if (bclk_gen_r) begin
          // frame toggles on a falling bit clock edge
          if (bitcnt_r == half_last) begin
            bitcnt_r    <= '0;
            frame_gen_r <= ~frame_gen_r;
          end else begin
            bitcnt_r <= 5'(bitcnt_r + 5'h01);
          end
        end
      end else begin
        div_r <= HALF_W'(div_r + 1'b1);
      end
    end
  end

  assign o_bit_clk_out   = bclk_gen_r;
  assign o_frame_clk_out = frame_gen_r;

  // one edge detector serves both clock sources
  assign bclk_lv = master ? bclk_gen_r  : sync_q[1];
  assign frm_lv  = master ? frame_gen_r : sync_q[0];

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      bclk_q_r <= 1'b0;
      frm_q_r  <= 1'b0;
    end else if (i_clk_en) begin
      bclk_q_r <= bclk_lv;
      frm_q_r  <= frm_lv;
    end
  end

  assign rise_e   = bclk_lv & ~bclk_q_r;
  assign fall_e   = ~bclk_lv & bclk_q_r;
  assign frm_rise = frm_lv & ~frm_q_r;
  assign frm_fall = ~frm_lv & frm_q_r;

  assign launch_e   = (fmt == FMT_DSP) ? (pol ? fall_e : rise_e) : fall_e;
  assign dsp_start  = (fmt == FMT_DSP) && frm_rise;
  assign frame_edge = fmt[1] && (frm_rise || frm_fall);
  assign load_word  = frm_rise ? held_r : word_r;

  // where the DSP MSB lands relative to the first bit clock pulse
  always_comb begin
    first_emit = 1'b0;
    // a wait state left over from DSP must not launch in the other formats
    if (fmt == FMT_DSP) begin
      case (st_r)
        DSP_WAIT_R1: first_emit = rise_e && !pol && !shift;
        DSP_WAIT_F1: first_emit = fall_e && pol;
        DSP_WAIT_R2: first_emit = rise_e;
        default:     first_emit = 1'b0;
      endcase
    end
  end

  assign run_emit = (st_r == DSP_RUN) && launch_e;

  // serial engine
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_r    <= DSP_IDLE;
      shift_r <= '0;
      left_r  <= '0;
      sdo_r   <= 1'b0;
      word_r  <= '0;
    end else if (i_clk_en) begin
      if (fmt == FMT_RSVD) begin
        st_r   <= DSP_IDLE;
        sdo_r  <= 1'b0;
        left_r <= '0;
      end else if (dsp_start) begin
        word_r  <= held_r;
        shift_r <= {held_r, held_r};
        left_r  <= 6'h20;
        st_r    <= DSP_WAIT_R1;
      end else if (frame_edge) begin
        if (frm_rise) begin
          word_r <= held_r;
        end
        if (fmt == FMT_MSBJ) begin
          sdo_r   <= load_word[SAMPLE_W-1];
          shift_r <= {load_word[SAMPLE_W-2:0], 17'h00000};
          left_r  <= 6'h0F;
        end else begin
          shift_r <= {load_word, 16'h0000};
          left_r  <= 6'h10;
        end
        st_r <= DSP_RUN;
      end else if (first_emit || run_emit) begin
        if (left_r != 6'h00) begin
          sdo_r   <= shift_r[31];
          shift_r <= {shift_r[30:0], 1'b0};
          left_r  <= 6'(left_r - 6'h01);
          st_r    <= DSP_RUN;
        end else begin
          sdo_r <= 1'b0;
          st_r  <= DSP_IDLE;
        end
      end else if ((st_r == DSP_WAIT_R1) && rise_e) begin
        st_r <= DSP_WAIT_F1;
      end else if ((st_r == DSP_WAIT_F1) && fall_e) begin
        st_r <= DSP_WAIT_R2;
      end
    end
  end

  assign o_serial_data_out = sdo_r;

  default clocking cb @(posedge i_clock);
  endclocking

  default disable iff (!i_resetn);

  msb_first_a: assert property (
    (fmt == FMT_MSBJ && frame_edge && i_clk_en) |=> sdo_r == $past(load_word[SAMPLE_W-1])
  ) else $error("justified MSB not sent at frame edge");

  rsvd_quiet_a: assert property (
    (fmt == FMT_RSVD && i_clk_en) |=> (sdo_r == 1'b0 && st_r == DSP_IDLE)
  ) else $error("reserved format still transmits");

  slave_pins_a: assert property (
    (!master && i_clk_en) |=> (!o_bit_clk_out && !o_frame_clk_out)
  ) else $error("clock outputs driven in slave mode");

  fall_launch_a: assert property (
    ($changed(sdo_r) && $past(fmt[1]) && $past(i_clk_en)) |-> $past(fall_e)
  ) else $error("justified or I2S data changed off a falling edge");

  dsp_edge_a: assert property (
    ($changed(sdo_r) && $past(fmt) == FMT_DSP && $past(i_clk_en))
      |-> ($past(pol) ? $past(fall_e) : $past(rise_e))
  ) else $error("DSP data changed on the wrong edge");

  dsp_dup_a: assert property (
    (dsp_start && i_clk_en) |=> (shift_r[31:16] == shift_r[15:0] && left_r == 6'h20)
  ) else $error("DSP frame halves differ");

  half_word_a: assert property (
    (frame_edge && frm_fall && i_clk_en) |=> word_r == $past(word_r)
  ) else $error("second half word differs from first");

  first_rise_a: assert property (
    (fmt == FMT_DSP && st_r == DSP_WAIT_R1 && rise_e && !pol && !shift && !frm_rise && i_clk_en)
      |=> (sdo_r == $past(shift_r[31]) && st_r == DSP_RUN)
  ) else $error("MSB missed the first rising edge");

  first_fall_a: assert property (
    (fmt == FMT_DSP && st_r == DSP_WAIT_F1 && fall_e && pol && !frm_rise && i_clk_en)
      |=> sdo_r == $past(shift_r[31])
  ) else $error("MSB missed the first falling edge");

  shift_wait_a: assert property (
    (fmt == FMT_DSP && st_r == DSP_WAIT_R1 && rise_e && shift && !frm_rise && i_clk_en)
      |=> st_r == DSP_WAIT_F1 ##0 sdo_r == $past(sdo_r)
  ) else $error("shifted MSB sent too early");

  frame_len_a: assert property (
    (master && $past(master) && $changed(frame_gen_r)) |-> $past(bitcnt_r == half_last)
  ) else $error("master frame half has the wrong bit count");

  i2s_half_a: assert property (
    (fmt == FMT_I2S && frame_edge && frm_fall && i_clk_en) |=> shift_r[31:16] == word_r
  ) else $error("I2S low half carries a different word");

  msbj_half_a: assert property (
    (fmt == FMT_MSBJ && frame_edge && frm_fall && i_clk_en)
      |=> {sdo_r, shift_r[31:17]} == word_r
  ) else $error("justified low half carries a different word");

  hold_when_off_a: assert property (
    !i_clk_en |=> ($stable(sdo_r) && $stable(st_r) && $stable(frame_gen_r) && $stable(ctrl_r))
  ) else $error("state moved while the clock enable was low");

  rdata_once_a: assert property (
    (i_clk_en && !i_rd) |=> o_rdata == '0
  ) else $error("read data outlived its cycle");

  dsp_frame_c: cover property (dsp_start && i_clk_en);
  i2s_frame_c: cover property (fmt == FMT_I2S && frame_edge && i_clk_en);
  fast_rate_c: cover property (master && rate == RATE_64FS && frm_rise);
  slave_msbj_c: cover property (!master && fmt == FMT_MSBJ && frm_fall);
  dsp_shift_c: cover property (st_r == DSP_WAIT_R2 && rise_e && i_clk_en);

endmodule : audio_serial_out

// ===== verilog/pin_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic         i_clk_en,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  generate
    if (W < 1) begin : g_bad_width
      $error("W must be at least one");
    end
  endgenerate

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      meta_r <= '0;
      o_q    <= '0;
    end else if (i_clk_en) begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule : pin_sync
